// file: bridge_cfg_pkg.sv
package bridge_cfg_pkg;

  // configuration byte offsets
  localparam logic [7:0] OFS_STATUS_LO   = 8'h06;
  localparam logic [7:0] OFS_STATUS_HI   = 8'h07;
  localparam logic [7:0] OFS_REVISION    = 8'h08;
  localparam logic [7:0] OFS_SUBCLASS    = 8'h0A;
  localparam logic [7:0] OFS_BASE_CLASS  = 8'h0B;
  localparam logic [7:0] OFS_LATENCY     = 8'h0D;
  localparam logic [7:0] OFS_HEADER      = 8'h0E;

  // primary status field positions
  localparam int STS_PARITY_FAULT   = 15;
  localparam int STS_SYS_ERR_SENT   = 14;
  localparam int STS_GOT_INIT_ABORT = 13;
  localparam int STS_GOT_RESP_ABORT = 12;
  localparam int STS_GAVE_ABORT     = 11;
  localparam int STS_DECODE_LSB     = 9;
  localparam int STS_DATA_PARITY    = 8;
  localparam int STS_BACK_TO_BACK   = 7;
  localparam int STS_HIGH_SPEED     = 5;
  localparam int STS_SYS_ERR_BYTE   = 6;  // position inside the upper byte

  // fixed values
  localparam logic [15:0] PRIMARY_STATUS_RESET = 16'h00A0;
  localparam logic [1:0]  DECODE_SPEED_FAST    = 2'h0;
  localparam logic [7:0]  SUBCLASS_VALUE       = 8'h04;
  localparam logic [7:0]  BASE_CLASS_VALUE     = 8'h06;
  localparam logic [7:0]  HEADER_VALUE         = 8'h01;
  localparam int          LATENCY_LSB          = 3;
  localparam int          LATENCY_WIDTH        = 5;
  localparam logic [4:0]  LATENCY_RESET        = 5'h00;
  localparam int          ERR_COND_COUNT       = 4;

  // configuration access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;

  // configuration read answer
  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } cfg_rsp_t;

endpackage

// file: serr_message_gen.sv
`timescale 1ns/100ps
module serr_message_gen
  import bridge_cfg_pkg::*;
#(
  parameter int COND_COUNT = ERR_COND_COUNT
) (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // error sources and enables
  input  wire logic [COND_COUNT-1:0] err_event_i,
  input  wire logic [COND_COUNT-1:0] err_cond_enable_i,
  input  wire logic                  system_error_msg_enable_i,
  // message toward the hub link
  output logic                       hub_link_serr_msg_o
);

  typedef struct packed {
    logic msg;
  } gen_state_t;

  gen_state_t                st;
  gen_state_t                next_st;
  logic [COND_COUNT-1:0]     gated;

  // per-condition gating by its own enable
  for (genvar i = 0; i < COND_COUNT; i++) begin : g_gate
    assign gated[i] = err_event_i[i] & err_cond_enable_i[i];
  end

  // message only under the global enable
  always_comb begin
    next_st     = st;
    next_st.msg = system_error_msg_enable_i & (|gated);
  end

  // state register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hub_link_serr_msg_o = st.msg;

  chk_msg_gating: assert property (
    @(posedge clock_i) disable iff (reset_i)
    hub_link_serr_msg_o |->
      $past(system_error_msg_enable_i) && ($past(err_event_i & err_cond_enable_i) != '0))
    else $error("system error message sent without enable");

  chk_msg_follows: assert property (
    @(posedge clock_i) disable iff (reset_i)
    system_error_msg_enable_i && ((err_event_i & err_cond_enable_i) != '0)
      |=> hub_link_serr_msg_o)
    else $error("enabled error condition sent no message");

endmodule

// file: bridge_config_header_regs.sv
`timescale 1ns/100ps
module bridge_config_header_regs
  import bridge_cfg_pkg::*;
#(
  parameter int COND_COUNT = ERR_COND_COUNT
) (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // configuration access
  input  wire cfg_req_t              cfg_req_i,
  output cfg_rsp_t                   cfg_rsp_o,
  // revision of the primary host bridge function
  input  wire logic [7:0]            revision_number_i,
  // error sources and enables
  input  wire logic [COND_COUNT-1:0] err_event_i,
  input  wire logic [COND_COUNT-1:0] err_cond_enable_i,
  input  wire logic                  system_error_msg_enable_i,
  // hub link message and status view
  output logic                       hub_link_serr_msg_o,
  output logic                       system_error_sent_flag_o
);

  typedef struct packed {
    logic                     system_error_sent_flag;
    logic [LATENCY_WIDTH-1:0] scratch;
    cfg_rsp_t                 rsp;
  } regs_state_t;

  regs_state_t  st;
  regs_state_t  next_st;
  logic [15:0]  status;
  logic         sse_clear;
  logic [7:0]   read_value;

  // message path toward the hub link
  serr_message_gen #(
    .COND_COUNT(COND_COUNT)
  ) u_serr_gen (
    .clock_i                   (clock_i),
    .reset_i                   (reset_i),
    .err_event_i               (err_event_i),
    .err_cond_enable_i         (err_cond_enable_i),
    .system_error_msg_enable_i (system_error_msg_enable_i),
    .hub_link_serr_msg_o       (hub_link_serr_msg_o)
  );

  // primary status word from constants and the one live flag
  always_comb begin
    status                                  = '0;
    status[STS_PARITY_FAULT]                = 1'b0;
    status[STS_DATA_PARITY]                 = 1'b0;
    status[STS_SYS_ERR_SENT]                = st.system_error_sent_flag;
    status[STS_GOT_INIT_ABORT]              = 1'b0;
    status[STS_GOT_RESP_ABORT]              = 1'b0;
    status[STS_GAVE_ABORT]                  = 1'b0;
    status[STS_DECODE_LSB +: 2]             = DECODE_SPEED_FAST;
    status[STS_BACK_TO_BACK]                = 1'b1;
    status[STS_HIGH_SPEED]                  = 1'b1;
  end

  // read decode, unmapped and reserved read zero
  always_comb begin
    case (cfg_req_i.addr)
      OFS_STATUS_LO:  read_value = status[7:0];
      OFS_STATUS_HI:  read_value = status[15:8];
      OFS_REVISION:   read_value = revision_number_i;
      OFS_SUBCLASS:   read_value = SUBCLASS_VALUE;
      OFS_BASE_CLASS: read_value = BASE_CLASS_VALUE;
      OFS_LATENCY:    read_value = {st.scratch, 3'h0};
      OFS_HEADER:     read_value = HEADER_VALUE;
      default:        read_value = 8'h00;
    endcase
  end

  // write-one-to-clear strobe for the system error flag
  assign sse_clear = cfg_req_i.wr && (cfg_req_i.addr == OFS_STATUS_HI)
                     && cfg_req_i.wdata[STS_SYS_ERR_BYTE];

  // next state: set wins over clear, scratch is the only plain writable field, the flag is write-one-to-clear
  always_comb begin
    next_st            = st;
    next_st.system_error_sent_flag        = (st.system_error_sent_flag & ~sse_clear) | hub_link_serr_msg_o;
    if (cfg_req_i.wr && (cfg_req_i.addr == OFS_LATENCY)) begin
      next_st.scratch  = cfg_req_i.wdata[LATENCY_LSB +: LATENCY_WIDTH];
    end
    next_st.rsp.rvalid = cfg_req_i.rd;
    next_st.rsp.rdata  = cfg_req_i.rd ? read_value : 8'h00;
  end

  // state register, reset clears flag and scratchpad
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st         <= '0;
      st.scratch <= LATENCY_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rsp_o                = st.rsp;
  assign system_error_sent_flag_o = st.system_error_sent_flag;

  // checks
  chk_parity_zero: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_STATUS_HI
      |=> cfg_rsp_o.rdata[7] == 1'b0 && cfg_rsp_o.rdata[0] == 1'b0)
    else $error("parity flags not zero");

  chk_sse_set: assert property (
    @(posedge clock_i) disable iff (reset_i)
    hub_link_serr_msg_o |=> system_error_sent_flag_o)
    else $error("system error flag not set by message");

  chk_sse_hold: assert property (
    @(posedge clock_i) disable iff (reset_i)
    system_error_sent_flag_o && !sse_clear |=> system_error_sent_flag_o)
    else $error("system error flag lost without clear");

  chk_sse_clear: assert property (
    @(posedge clock_i) disable iff (reset_i)
    sse_clear && !hub_link_serr_msg_o |=> !system_error_sent_flag_o)
    else $error("system error flag not cleared");

  chk_abort_decode: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_STATUS_HI |=> cfg_rsp_o.rdata[5:1] == 5'h00)
    else $error("abort or decode bits not zero");

  chk_low_caps: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_STATUS_LO |=> cfg_rsp_o.rdata == 8'hA0)
    else $error("low status byte wrong");

  chk_revision_mirror: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_REVISION
      |=> cfg_rsp_o.rvalid && cfg_rsp_o.rdata == $past(revision_number_i))
    else $error("revision mismatch");

  chk_class_codes: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && (cfg_req_i.addr == OFS_SUBCLASS || cfg_req_i.addr == OFS_BASE_CLASS)
      |=> cfg_rsp_o.rdata == (($past(cfg_req_i.addr) == OFS_SUBCLASS) ? 8'h04 : 8'h06))
    else $error("class code wrong");

  chk_scratch_readback: assert property (
    @(posedge clock_i) disable iff (reset_i)
    (cfg_req_i.wr && cfg_req_i.addr == OFS_LATENCY)
      ##1 (cfg_req_i.rd && !cfg_req_i.wr && cfg_req_i.addr == OFS_LATENCY)
      |=> cfg_rsp_o.rdata == ($past(cfg_req_i.wdata, 2) & 8'hF8))
    else $error("scratchpad readback wrong");

  chk_header_type: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_HEADER |=> cfg_rsp_o.rdata == 8'h01)
    else $error("header type wrong");

  chk_unmapped_zero: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr > OFS_HEADER |=> cfg_rsp_o.rdata == 8'h00)
    else $error("unmapped read not zero");

  chk_read_answer: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd |=> cfg_rsp_o.rvalid)
    else $error("read not answered");

  chk_idle_quiet: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !cfg_req_i.rd |=> !cfg_rsp_o.rvalid && cfg_rsp_o.rdata == 8'h00)
    else $error("answer without read");

  chk_latency_reserved: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_LATENCY |=> cfg_rsp_o.rdata[2:0] == 3'h0)
    else $error("latency reserved bits not zero");

  chk_scratch_hold: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !(cfg_req_i.wr && cfg_req_i.addr == OFS_LATENCY) |=> $stable(st.scratch))
    else $error("scratchpad changed without write");

  chk_sse_needs_msg: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !system_error_sent_flag_o && !hub_link_serr_msg_o |=> !system_error_sent_flag_o)
    else $error("system error flag set without message");

  chk_status_flag_view: assert property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_STATUS_HI
      |=> cfg_rsp_o.rdata[6] == $past(system_error_sent_flag_o))
    else $error("status read does not show the flag");

  cov_sse_set: cover property (
    @(posedge clock_i) disable iff (reset_i)
    hub_link_serr_msg_o ##1 system_error_sent_flag_o);

  cov_sse_cleared: cover property (
    @(posedge clock_i) disable iff (reset_i)
    system_error_sent_flag_o ##1 !system_error_sent_flag_o);

  cov_set_and_clear: cover property (
    @(posedge clock_i) disable iff (reset_i)
    sse_clear && hub_link_serr_msg_o);

  cov_scratch_read: cover property (
    @(posedge clock_i) disable iff (reset_i)
    cfg_req_i.rd && cfg_req_i.addr == OFS_LATENCY && st.scratch != 5'h00);

  cov_write_then_read: cover property (
    @(posedge clock_i) disable iff (reset_i)
    (cfg_req_i.wr && cfg_req_i.addr == OFS_LATENCY)
      ##1 (cfg_req_i.rd && cfg_req_i.addr == OFS_LATENCY));

endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import bridge_cfg_pkg::*;
  // stimulus and observed signals
  logic       clock_i                   = 1'b0;
  logic       reset_i                   = 1'b1;
  cfg_req_t   cfg_req_i                 = '0;
  cfg_rsp_t   cfg_rsp_o;
  logic [7:0] revision_number_i         = 8'h3C;
  logic [3:0] err_event_i               = 4'h0;
  logic [3:0] err_cond_enable_i         = 4'h0;
  logic       system_error_msg_enable_i = 1'b0;
  logic       hub_link_serr_msg_o;
  logic       system_error_sent_flag_o;
  int         fail_count                = 0;
  int         samples_checked           = 0;
  int         cycles                    = 0;
  // offsets and their contents after reset
  logic [7:0] offs [7]                  = '{8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h20};
  logic [7:0] vals [7]                  = '{8'hA0, 8'h00, 8'h04, 8'h06, 8'h00, 8'h01, 8'h00};

  bridge_config_header_regs #(.COND_COUNT(4)) bridge_config_header_regs_inst (
    .clock_i                   (clock_i),
    .reset_i                   (reset_i),
    .cfg_req_i                 (cfg_req_i),
    .cfg_rsp_o                 (cfg_rsp_o),
    .revision_number_i         (revision_number_i),
    .err_event_i               (err_event_i),
    .err_cond_enable_i         (err_cond_enable_i),
    .system_error_msg_enable_i (system_error_msg_enable_i),
    .hub_link_serr_msg_o       (hub_link_serr_msg_o),
    .system_error_sent_flag_o  (system_error_sent_flag_o)
  );

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  // hang guard, far above the expected run length
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      summarize();
    end
  end

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one comparison on a byte
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // byte read, answer seen in the cycle after the taking edge
  task automatic cfg_read(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clock_i);
    cfg_req_i.rd = 1'b1;
    cfg_req_i.addr = addr;
    @(negedge clock_i);
    cfg_req_i.rd = 1'b0;
    check({7'h00, cfg_rsp_o.rvalid}, 8'h01, "read valid");
    check(cfg_rsp_o.rdata, exp, "read data");
  endtask

  // byte write, one-cycle strobe
  task automatic cfg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock_i);
    cfg_req_i.wr = 1'b1;
    cfg_req_i.addr = addr;
    cfg_req_i.wdata = data;
    @(negedge clock_i);
    cfg_req_i.wr = 1'b0;
  endtask

  // write then read at the very next edge, answer shows the new value
  task automatic cfg_write_read(input logic [7:0] addr, input logic [7:0] data,
                                input logic [7:0] exp);
    @(negedge clock_i);
    cfg_req_i.wr = 1'b1;
    cfg_req_i.addr = addr;
    cfg_req_i.wdata = data;
    @(negedge clock_i);
    cfg_req_i.wr = 1'b0;
    cfg_req_i.rd = 1'b1;
    @(negedge clock_i);
    cfg_req_i.rd = 1'b0;
    check({7'h00, cfg_rsp_o.rvalid}, 8'h01, "read valid");
    check(cfg_rsp_o.rdata, exp, "read data");
  endtask

  // one-cycle error event, then message and flag checks
  task automatic pulse_event(input logic [3:0] ev, input logic msg, input logic flag);
    @(negedge clock_i);
    err_event_i = ev;
    @(negedge clock_i);
    err_event_i = 4'h0;
    check({7'h00, hub_link_serr_msg_o}, {7'h00, msg}, "hub link message");
    @(negedge clock_i);
    check({7'h00, system_error_sent_flag_o}, {7'h00, flag}, "sent flag");
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    reset_i = 1'b0;
    for (int i = 0; i < 7; i++) cfg_read(offs[i], vals[i]);
    cfg_read(OFS_REVISION, 8'h3C);
    revision_number_i = 8'hC3;
    cfg_read(OFS_REVISION, 8'hC3);
    $display("test reset_values done");
    for (int i = 0; i < 7; i++) if (offs[i] != OFS_LATENCY) cfg_write(offs[i], 8'hFF);
    for (int i = 0; i < 7; i++) if (offs[i] != OFS_LATENCY) cfg_read(offs[i], vals[i]);
    $display("test read_only_writes done");
    cfg_write(OFS_LATENCY, 8'hFF);
    cfg_read(OFS_LATENCY, 8'hF8);
    cfg_write(OFS_LATENCY, 8'h57);
    cfg_read(OFS_LATENCY, 8'h50);
    cfg_write_read(OFS_LATENCY, 8'hA9, 8'hA8);
    $display("test scratchpad done");
    pulse_event(4'hF, 1'b0, 1'b0);
    system_error_msg_enable_i = 1'b1;
    err_cond_enable_i = 4'h5;
    pulse_event(4'hA, 1'b0, 1'b0);
    pulse_event(4'h4, 1'b1, 1'b1);
    cfg_read(OFS_STATUS_HI, 8'h40);
    cfg_read(OFS_STATUS_LO, 8'hA0);
    cfg_write(OFS_STATUS_HI, 8'hBF);
    cfg_read(OFS_STATUS_HI, 8'h40);
    cfg_write(OFS_STATUS_HI, 8'h40);
    cfg_read(OFS_STATUS_HI, 8'h00);
    system_error_msg_enable_i = 1'b0;
    pulse_event(4'h1, 1'b0, 1'b0);
    $display("test system_error done");
    system_error_msg_enable_i = 1'b1;
    pulse_event(4'h1, 1'b1, 1'b1);
    @(negedge clock_i);
    err_event_i = 4'h1;
    @(negedge clock_i);
    err_event_i = 4'h0;
    cfg_req_i.wr = 1'b1;
    cfg_req_i.addr = OFS_STATUS_HI;
    cfg_req_i.wdata = 8'h40;
    @(negedge clock_i);
    cfg_req_i.wr = 1'b0;
    check({7'h00, system_error_sent_flag_o}, 8'h01, "flag kept when set meets clear");
    $display("test set_wins done");
    cfg_write(OFS_LATENCY, 8'hFF);
    @(negedge clock_i);
    reset_i = 1'b1;
    @(negedge clock_i);
    check({7'h00, system_error_sent_flag_o}, 8'h00, "flag in reset");
    reset_i = 1'b0;
    cfg_read(OFS_LATENCY, 8'h00);
    cfg_read(OFS_STATUS_HI, 8'h00);
    $display("test mid_run_reset done");
    summarize();
  end
endmodule
